// >>> rtl/counter_control.sv
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Control registers clear to zero on power-on or standby reset only.
// - Five control registers, one per channel zero to four.
// - Channels 0,3,4: clear select picks none, A, B, C, D or sync.
// - Synchronized clear acts only when the channel lockstep bit is set.
// - Compare C or D acting as buffer never clears the counter.
// - Channels 1,2: bit 7 reads zero; two-bit clear select none/A/B/sync.
// - Edge select: rising, falling, or both edges of count clock.
// - Both edges of a prescaled clock double the count rate.
// - Phase counting on channels 1,2 overrides the edge select.
// - Edge select ignored for phi/1 and overflow sources; rising used.
// - Each channel picks its count clock independently.
// - Channel 0 sources: phi/1,4,16,64 then pins A to D.
// - Channel 1 sources: phi/1..64, pin A, pin B, phi/256, ch2 overflow.
// - Channel 1 prescaler ignored in phase counting mode.
// - Channel 2 sources: phi/1..64, pins A, B, C, then phi/1024.
// - Channel 2 prescaler ignored in phase counting mode.
// - Channels 3,4 sources: phi/1..phi/1024, then pins A and B.
module counter_control (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcc_pkg::AW-1:0] paddr,
  input wire logic [tcc_pkg::DW-1:0] pwdata,
  output logic [tcc_pkg::DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_pin_a_i,
  input wire logic ext_count_pin_b_i,
  input wire logic ext_count_pin_c_i,
  input wire logic ext_count_pin_d_i,
  input wire logic ch2_overflow_i,
  input wire logic [1:0] phase_mode_i,
  input wire logic [tcc_pkg::NCH-1:0] lockstep_i,
  input wire logic [tcc_pkg::NCH-1:0] buf_a_i,
  input wire logic [tcc_pkg::NCH-1:0] buf_b_i,
  input wire tcc_pkg::match_s [tcc_pkg::NCH-1:0] match_i,
  output logic [tcc_pkg::NCH-1:0] count_en_o,
  output logic [tcc_pkg::NCH-1:0] clear_o
);
  import tcc_pkg::*;

  ctl_s [NCH-1:0] ctl_reg;
  ctl_s [NCH-1:0] ctl_next;
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] rdata_next;
  logic [DIV_W-1:0] div_reg;
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic [3:0] pin_prev_reg;
  logic [NCH-1:0] count_en_reg;
  logic [NCH-1:0] count_en_next;
  logic [NCH-1:0] clear_reg;
  logic [NCH-1:0] clear_next;

  // APB decode
  logic [NCH-1:0] hit_ch;
  logic [AW-1:0] off_tab [NCH];
  wire logic addr_hit;
  wire logic setup_phase;
  wire logic wr_access;

  assign off_tab[0] = OFF_CTL0;
  assign off_tab[1] = OFF_CTL1;
  assign off_tab[2] = OFF_CTL2;
  assign off_tab[3] = OFF_CTL3;
  assign off_tab[4] = OFF_CTL4;

  assign addr_hit = |hit_ch;
  assign setup_phase = psel & ~penable;
  assign wr_access = psel & penable & pwrite & addr_hit;

  // Zero wait states; a miss answers with an error and no write
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;
  assign prdata = rdata_reg;

  // Shared prescaler, pin conditioning
  logic [NDIV-1:0] div_rise;
  logic [NDIV-1:0] div_fall;
  wire logic [3:0] pin_rise;
  wire logic [3:0] pin_fall;
  logic [NSRC-1:0] src_rise;
  logic [NSRC-1:0] src_fall;

  // Divided clock phi/2^k is modelled as div_reg[k-1]; its edges become
  // single-cycle enables so the counters never leave the phi domain.
  genvar d;
  generate
    for (d = 0; d < NDIV; d++) begin : g_div
      localparam int K = 2 * d + 2;
      assign div_rise[d] =
        (div_reg[K-1:0] == {1'b0, {(K-1){1'b1}}});
      assign div_fall[d] = &div_reg[K-1:0];
    end
  endgenerate

  // Edge detector compares the second synchroniser stage with its one-cycle delayed copy
  assign pin_rise = pin_sync_reg & ~pin_prev_reg;
  assign pin_fall = ~pin_sync_reg & pin_prev_reg;

  // Phi/1 and overflow count once per event, edge select has no say
  assign src_rise[SRC_P1] = 1'b1;
  assign src_fall[SRC_P1] = 1'b0;
  assign src_rise[SRC_OVF] = ch2_overflow_i;
  assign src_fall[SRC_OVF] = 1'b0;
  assign src_rise[SRC_P1024:SRC_P4] = div_rise;
  assign src_fall[SRC_P1024:SRC_P4] = div_fall;
  assign src_rise[SRC_PD:SRC_PA] = pin_rise;
  assign src_fall[SRC_PD:SRC_PA] = pin_fall;

  // Lockstep clear: any synchronized channel clearing on its own match
  logic [NCH-1:0] match_clr;
  logic [NCH-1:0] sync_want;
  wire logic sync_evt;

  assign sync_evt = |(match_clr & lockstep_i);

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      localparam logic [7:0] WMASK =
        (i == 1 || i == 2) ? WMASK_NARROW : WMASK_WIDE;
      ctl_s c;
      logic [3:0] src;
      logic rise;
      logic fall;
      logic fixed;
      logic tick;
      logic phase_blk;
      logic cl_grp;
      logic [1:0] cl_sel;
      logic hit_cd_a;
      logic hit_cd_b;
      logic ma;
      logic mb;

      assign hit_ch[i] = (paddr == off_tab[i]);

      // Bit 7 of channels 1 and 2 has no flop behind it
      assign ctl_next[i] = wr_access & hit_ch[i] ?
        ctl_s'(pwdata[7:0] & WMASK) : ctl_reg[i];

      assign c = ctl_reg[i];

      // Per-channel table lookup of the count source
      assign src = SRC_MAP[i][c.psc];
      assign rise = src_rise[src];
      assign fall = src_fall[src];
      assign fixed = (src == SRC_P1) || (src == SRC_OVF);

      // Both edges of phi/N give twice the rate of rising only
      assign tick = fixed ? rise :
        (c.edge_sel == EDGE_RISE) ? rise :
        (c.edge_sel == EDGE_FALL) ? fall :
        (rise | fall);

      if (i == 1) begin : g_ph1
        assign phase_blk = phase_mode_i[0];
      end else if (i == 2) begin : g_ph2
        assign phase_blk = phase_mode_i[1];
      end else begin : g_ph_none
        assign phase_blk = 1'b0;
      end

      // Phase counting datapath owns the counter, so no enable here
      assign count_en_next[i] = tick & ~phase_blk;

      assign cl_grp = c.clr[2];
      assign cl_sel = c.clr[1:0];

      // Buffer-mode C or D produce no match, hence no clear
      assign hit_cd_a = match_i[i].c & ~buf_a_i[i];
      assign hit_cd_b = match_i[i].d & ~buf_b_i[i];
      assign ma = cl_grp ? hit_cd_a : match_i[i].a;
      assign mb = cl_grp ? hit_cd_b : match_i[i].b;

      assign match_clr[i] =
        ((cl_sel == CLR_A) & ma) |
        ((cl_sel == CLR_B) & mb);

      assign sync_want[i] =
        (cl_sel == CLR_SYNC) & lockstep_i[i];

      assign clear_next[i] =
        match_clr[i] | (sync_want[i] & sync_evt);
    end
  endgenerate

  // Read mux, loaded in the setup phase so data comes from a flop
  always_comb begin
    rdata_next = '0;
    for (int n = 0; n < NCH; n++) begin
      if (hit_ch[n]) begin
        rdata_next = {{(DW-8){1'b0}}, ctl_reg[n]};
      end
    end
  end

  // No manual-reset input exists: only rst_i may reset the controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_reg <= {NCH{CTL_RESET}};
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else if (setup_phase) begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_prev_reg <= '0;
    end else begin
      pin_meta_reg <= {ext_count_pin_d_i, ext_count_pin_c_i,
                       ext_count_pin_b_i, ext_count_pin_a_i};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_en_reg <= '0;
      clear_reg <= '0;
    end else begin
      count_en_reg <= count_en_next;
      clear_reg <= clear_next;
    end
  end

  assign count_en_o = count_en_reg;
  assign clear_o = clear_reg;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  wire logic b3_both;
  assign b3_both = (ctl_reg[3].psc == 3'h1) && ctl_reg[3].edge_sel[1];

  chk_reset_zero: assert property (
    @(posedge clk_i) disable iff (1'b0)
    rst_i |=> (ctl_reg == '0))
    else $error("control register not zero after reset");

  chk_bit7_zero: assert property (
    wr_access |=> !ctl_reg[1].clr[2] && !ctl_reg[2].clr[2])
    else $error("channel 1 or 2 bit 7 became set");

  chk_phi1_every: assert property (
    (ctl_reg[0].psc == 3'h0) |=> count_en_o[0])
    else $error("phi/1 did not enable every cycle");

  chk_phase_block: assert property (
    phase_mode_i[0] |=> !count_en_o[1])
    else $error("channel 1 counted in phase mode");

  chk_buf_noclear: assert property (
    (ctl_reg[0].clr == 3'h5) && buf_a_i[0] |=> !clear_o[0])
    else $error("buffer register C cleared the counter");

  chk_sync_gate: assert property (
    (ctl_reg[3].clr[1:0] == CLR_SYNC) && !lockstep_i[3]
    |=> !clear_o[3])
    else $error("sync clear without lockstep");

  chk_match_a: assert property (
    (ctl_reg[0].clr == 3'h1) && match_i[0].a |=> clear_o[0])
    else $error("match A did not clear");

  chk_both_rate: assert property (
    ($past(b3_both) && b3_both && count_en_o[3]) ##1 b3_both
    |-> !count_en_o[3] ##1 count_en_o[3])
    else $error("both-edge phi/4 not every second cycle");

  chk_fall_edge: assert property (
    (ctl_reg[4].psc == 3'h1) && (ctl_reg[4].edge_sel == EDGE_FALL) &&
    (div_reg[1:0] == 2'h3) |=> count_en_o[4])
    else $error("falling-edge phi/4 missed its enable");

  chk_rise_only: assert property (
    (ctl_reg[0].psc == 3'h1) && (ctl_reg[0].edge_sel == EDGE_RISE) &&
    (div_reg[1:0] != 2'h1) |=> !count_en_o[0])
    else $error("rising-edge phi/4 enabled off its edge");

  chk_fixed_rise: assert property (
    (ctl_reg[2].psc == 3'h0) && !phase_mode_i[1] |=> count_en_o[2])
    else $error("phi/1 on channel 2 skipped a cycle");

  chk_ovf_follow: assert property (
    (ctl_reg[1].psc == 3'h7) && !phase_mode_i[0]
    |=> count_en_o[1] == $past(ch2_overflow_i))
    else $error("channel 1 enable does not follow overflow");

  chk_ch2_phase: assert property (
    phase_mode_i[1] |=> !count_en_o[2])
    else $error("channel 2 counted in phase mode");

  chk_ch2_slow: assert property (
    (ctl_reg[2].psc == 3'h7) && (ctl_reg[2].edge_sel == EDGE_RISE) &&
    (div_reg != 10'h1ff) |=> !count_en_o[2])
    else $error("phi/1024 on channel 2 enabled off its edge");

  chk_ch2_pin_c: assert property (
    (ctl_reg[2].psc == 3'h6) && (ctl_reg[2].edge_sel == EDGE_RISE) &&
    !phase_mode_i[1] |=> count_en_o[2] ==
    ($past(ext_count_pin_c_i, 3) && !$past(ext_count_pin_c_i, 4)))
    else $error("pin C rise not seen three edges later");

  chk_pin_a_rise: assert property (
    (ctl_reg[0].psc == 3'h4) && (ctl_reg[0].edge_sel == EDGE_RISE)
    |=> count_en_o[0] ==
    ($past(ext_count_pin_a_i, 3) && !$past(ext_count_pin_a_i, 4)))
    else $error("pin A rise not seen three edges later");

  chk_pin_a_both: assert property (
    (ctl_reg[3].psc == 3'h6) && ctl_reg[3].edge_sel[1]
    |=> count_en_o[3] ==
    ($past(ext_count_pin_a_i, 3) != $past(ext_count_pin_a_i, 4)))
    else $error("pin A edge on channel 3 not counted");

  chk_pin_b_fall: assert property (
    (ctl_reg[4].psc == 3'h7) && (ctl_reg[4].edge_sel == EDGE_FALL)
    |=> count_en_o[4] ==
    (!$past(ext_count_pin_b_i, 3) && $past(ext_count_pin_b_i, 4)))
    else $error("pin B fall on channel 4 not counted");

  chk_ch3_slow: assert property (
    (ctl_reg[3].psc == 3'h4) && (ctl_reg[3].edge_sel == EDGE_RISE) &&
    (div_reg[7:0] != 8'h7f) |=> !count_en_o[3])
    else $error("phi/256 on channel 3 enabled off its edge");

  chk_clear_d: assert property (
    (ctl_reg[0].clr == 3'h6) && match_i[0].d && !buf_b_i[0]
    |=> clear_o[0])
    else $error("match D did not clear");

  chk_no_clear: assert property (
    (ctl_reg[0].clr[1:0] == CLR_NONE) |=> !clear_o[0])
    else $error("disabled clear select still cleared");

  chk_sync_follow: assert property (
    (ctl_reg[0].clr[1:0] == CLR_SYNC) && lockstep_i[0] &&
    lockstep_i[3] && (ctl_reg[3].clr == 3'h1) && match_i[3].a
    |=> clear_o[0])
    else $error("lockstep channel missed a sync clear");

  chk_ch1_bclear: assert property (
    (ctl_reg[1].clr[1:0] == CLR_B) && match_i[1].b |=> clear_o[1])
    else $error("match B on channel 1 did not clear");

  cov_both_edge: cover property (b3_both ##1 count_en_o[3]);
  cov_sync_clr: cover property (|(sync_want & clear_o));
  cov_ext_pin: cover property ((ctl_reg[0].psc == 3'h4) ##1 count_en_o[0]);
  cov_ovf: cover property ((ctl_reg[1].psc == 3'h7) ##1 count_en_o[1]);

endmodule : counter_control

`default_nettype wire

// >>> rtl/tcc_pkg.sv
package tcc_pkg;

  localparam int NCH = 5;
  localparam int AW = 12;
  localparam int DW = 32;

  localparam logic [AW-1:0] OFF_CTL0 = 12'h000;
  localparam logic [AW-1:0] OFF_CTL1 = 12'h004;
  localparam logic [AW-1:0] OFF_CTL2 = 12'h008;
  localparam logic [AW-1:0] OFF_CTL3 = 12'h00c;
  localparam logic [AW-1:0] OFF_CTL4 = 12'h010;

  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] WMASK_WIDE = 8'hff;
  localparam logic [7:0] WMASK_NARROW = 8'h7f;

  localparam int DIV_W = 10;
  localparam int NDIV = 5;

  localparam int NSRC = 11;
  localparam logic [3:0] SRC_P1 = 4'h0;
  localparam logic [3:0] SRC_P4 = 4'h1;
  localparam logic [3:0] SRC_P16 = 4'h2;
  localparam logic [3:0] SRC_P64 = 4'h3;
  localparam logic [3:0] SRC_P256 = 4'h4;
  localparam logic [3:0] SRC_P1024 = 4'h5;
  localparam logic [3:0] SRC_PA = 4'h6;
  localparam logic [3:0] SRC_PB = 4'h7;
  localparam logic [3:0] SRC_PC = 4'h8;
  localparam logic [3:0] SRC_PD = 4'h9;
  localparam logic [3:0] SRC_OVF = 4'ha;

  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;

  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_A = 2'h1;
  localparam logic [1:0] CLR_B = 2'h2;
  localparam logic [1:0] CLR_SYNC = 2'h3;

  localparam logic [0:4][0:7][3:0] SRC_MAP = '{
    '{SRC_P1, SRC_P4, SRC_P16, SRC_P64, SRC_PA, SRC_PB, SRC_PC, SRC_PD},
    '{SRC_P1, SRC_P4, SRC_P16, SRC_P64, SRC_PA, SRC_PB, SRC_P256, SRC_OVF},
    '{SRC_P1, SRC_P4, SRC_P16, SRC_P64, SRC_PA, SRC_PB, SRC_PC, SRC_P1024},
    '{SRC_P1, SRC_P4, SRC_P16, SRC_P64, SRC_P256, SRC_P1024, SRC_PA, SRC_PB},
    '{SRC_P1, SRC_P4, SRC_P16, SRC_P64, SRC_P256, SRC_P1024, SRC_PA, SRC_PB}
  };

  typedef struct packed {
    logic [2:0] clr;
    logic [1:0] edge_sel;
    logic [2:0] psc;
  } ctl_s;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } match_s;

endpackage : tcc_pkg

// >>> testbench/pin_source.sv
`timescale 1ns/1ps
`default_nettype none

// Far side: external count pins and a sibling channel's overflow
module pin_source (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [1:0] pin_sel_i,
  output logic [3:0] pin_o,
  output logic ovf_o
);
  initial begin
    pin_o = 4'h0;
    ovf_o = 1'b0;
  end

  // Eight pulses with no phase tie to the clock; pins idle low between runs
  always @(posedge go_i) begin
    repeat (8) begin
      #345 pin_o[pin_sel_i] = 1'b1;
      #465 pin_o[pin_sel_i] = 1'b0;
    end
  end

  // Sibling overflow is a one-cycle pulse in our own clock domain
  always @(posedge go_i) begin
    repeat (8) begin
      repeat (4) @(posedge clk_i);
      ovf_o <= 1'b1;
      @(posedge clk_i);
      ovf_o <= 1'b0;
    end
  end
endmodule : pin_source

`default_nettype wire

// >>> testbench/timer_counter_control_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module timer_counter_control_select_tb_top;
  import tcc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [DW-1:0] pwdata = '0;
  logic [DW-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] pin;
  logic ovf;
  logic go = 1'b0;
  logic [1:0] pin_sel = 2'h0;
  logic [1:0] phase = 2'h0;
  logic [NCH-1:0] lockstep = '0;
  logic [NCH-1:0] buf_a = '0;
  logic [NCH-1:0] buf_b = '0;
  match_s [NCH-1:0] match = '0;
  logic [NCH-1:0] count_en;
  logic [NCH-1:0] clear;
  logic counting = 1'b0;
  logic [DW-1:0] rd;
  logic err;
  int cnt [NCH];
  int n_mismatch = 0;
  int total_checks = 0;
  logic [AW-1:0] offs [NCH] = '{OFF_CTL0, OFF_CTL1, OFF_CTL2, OFF_CTL3,
                               OFF_CTL4};
  logic [3:0] sel0 [8] = '{4'h0, 4'h8, 4'h4, 4'h0, 4'h0, 4'h2, 4'h1, 4'h0};

  always #50 clk_i = ~clk_i;

  counter_control i_dut (.clk_i(clk_i), .rst_i(rst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_pin_a_i(pin[0]), .ext_count_pin_b_i(pin[1]),
    .ext_count_pin_c_i(pin[2]), .ext_count_pin_d_i(pin[3]),
    .ch2_overflow_i(ovf), .phase_mode_i(phase), .lockstep_i(lockstep),
    .buf_a_i(buf_a), .buf_b_i(buf_b), .match_i(match),
    .count_en_o(count_en), .clear_o(clear));

  pin_source i_far (.clk_i(clk_i), .go_i(go), .pin_sel_i(pin_sel),
    .pin_o(pin), .ovf_o(ovf));

  // Sampled mid-cycle so the enable flops have settled
  always @(negedge clk_i) begin
    if (counting) begin
      for (int i = 0; i < NCH; i++) begin
        cnt[i] += count_en[i];
      end
    end
  end

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [AW-1:0] a,
                     input logic [7:0] d);
    int w;
    w = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      w++;
    end while (pready !== 1'b1 && w < 20);
    if (w >= 20) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic set_all(input logic [8*NCH-1:0] v);
    for (int i = 0; i < NCH; i++) apb(1'b1, offs[i], v[8*i+:8]);
  endtask : set_all

  task automatic read_all(input logic [7:0] a, input logic [7:0] b);
    for (int i = 0; i < NCH; i++) begin
      apb(1'b0, offs[i], 8'h00);
      chk(rd, (i == 1 || i == 2) ? b : a);
    end
  endtask : read_all

  task automatic t_regs();
    read_all(8'h00, 8'h00);
    set_all({NCH{8'hff}});
    read_all(8'hff, 8'h7f);
    apb(1'b1, 12'h014, 8'h5a);
    chk({rd[30:0], err}, 32'h1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    read_all(8'h00, 8'h00);
  endtask : t_regs

  task automatic clr(input int ch, input logic [7:0] c, input logic [3:0] m,
                     input logic [NCH-1:0] e);
    apb(1'b1, offs[ch], c);
    @(posedge clk_i);
    match[ch] <= match_s'(m);
    @(posedge clk_i);
    match[ch] <= match_s'(4'h0);
    @(negedge clk_i);
    chk(clear, e);
    @(posedge clk_i);
  endtask : clr

  task automatic t_clear();
    logic [3:0] m;
    for (int c = 0; c < 8; c++) for (int j = 0; j < 4; j++) begin
      m = 4'h8 >> j;
      clr(0, 8'(c << 5), m, {4'h0, |(sel0[c] & m)});
    end
    for (int c = 0; c < 4; c++) for (int j = 0; j < 2; j++) begin
      m = 4'h8 >> j;
      clr(1, 8'h80 | 8'(c << 5), m, {3'h0, |(sel0[c] & m), 1'b0});
    end
    buf_a[0] <= 1'b1;
    clr(0, 8'ha0, 4'h2, '0);
    buf_b[3] <= 1'b1;
    clr(3, 8'hc0, 4'h1, '0);
    buf_a <= '0;
    buf_b <= '0;
    lockstep <= 5'b01001;
    apb(1'b1, offs[0], 8'h60);
    clr(3, 8'h20, 4'h8, 5'b01001);
    lockstep <= 5'b01000;
    clr(3, 8'h20, 4'h8, 5'b01000);
  endtask : t_clear

  // Free-running divider: any 1024-cycle window holds whole periods
  task automatic run(input logic [39:0] v, input logic [1:0] ph,
                     input logic g, input logic [59:0] e);
    phase <= ph;
    set_all(v);
    repeat (4) @(posedge clk_i);
    foreach (cnt[i]) cnt[i] = 0;
    counting <= 1'b1;
    go <= g;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (g ? 79 : 1023) @(posedge clk_i);
    counting <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < NCH; i++) chk(cnt[i], e[12*i+:12]);
  endtask : run

  task automatic t_rate();
    run(40'h0911070600, 2'h0, 1'b0, 60'h100200001004400);
    run(40'h0504101302, 2'h0, 1'b0, 60'h001004400020040);
    run(40'h1203000001, 2'h3, 1'b0, 60'h080010000000100);
  endtask : t_rate

  task automatic t_pins();
    for (int k = 0; k < 4; k++) begin
      pin_sel <= 2'(k);
      run({8'h0f, 8'h16, 8'h06, 8'h17, 8'(4 + k)}, 2'h0, 1'b1,
          {12'(k == 1 ? 8 : 0), 12'(k == 0 ? 16 : 0), 12'(k == 2 ? 8 : 0),
           12'd8, 12'd8});
    end
  endtask : t_pins

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_clear();
    t_rate();
    t_pins();
    final_report();
  end

  // Whole run is near 4000 cycles; allow plenty more
  initial begin
    #3000000;
    n_mismatch++;
    final_report();
  end
endmodule : timer_counter_control_select_tb_top

`default_nettype wire
